// File: shared/rnirq_pkg.sv
package rnirq_pkg;

  // Notification kinds
  typedef enum logic [2:0] {
    RNIRQ_N_IE_RX,
    RNIRQ_N_BCN_RX,
    RNIRQ_N_BCN_SIZE,
    RNIRQ_N_OCC_CHG,
    RNIRQ_N_SLOT_CHG,
    RNIRQ_N_CHAN_CHG,
    RNIRQ_N_UNK_CMD
  } rnirq_kind_t;

  // Beacon type codes
  localparam logic [1:0] BT_SCAN        = 2'h0;
  localparam logic [1:0] BT_NEIGHBOR    = 2'h1;
  localparam logic [1:0] BT_ALIEN_OVLP  = 2'h2;
  localparam logic [1:0] BT_ALIEN_NOVLP = 2'h3;

  // Element identifiers handled here (values arbitrary defaults)
  localparam logic [7:0] EID_PROBE       = 8'h08;
  localparam logic [7:0] EID_APP_SPEC    = 8'hFF;
  localparam logic [7:0] EID_APP_PROBE   = 8'h0F;
  localparam logic [7:0] EID_RELINQUISH  = 8'h0E;

  localparam int         ISRC_W          = 8;
  localparam logic [7:0] RST_SLOT        = 8'h00;

  // Beacon-received descriptor from the receive path
  typedef struct packed {
    logic [15:0] src_addr;
    logic [15:0] info_len;
    logic [7:0]  channel;
    logic [15:0] rx_time;
    logic [7:0]  lqi;
    logic [7:0]  rssi;
    logic [7:0]  slot;
    logic        signaling_slot;
    logic        beacon_period_start_time_aligned;
    logic        bp_overlap;
  } rnirq_bcn_t;

  // Notification record toward the event writer
  typedef struct packed {
    rnirq_kind_t kind;
    logic [15:0] src_addr;
    logic [15:0] length;
    logic [7:0]  channel;
    logic [1:0]  beacon_type;
    logic [15:0] rx_time;
    logic [7:0]  lqi;
    logic [7:0]  rssi;
    logic [7:0]  slot;
    logic        no_slot;
    logic [7:0]  context_id;
  } rnirq_note_t;

endpackage

// File: core/rnirq_logic.sv
// How it works
// - notify element received when target is us or a watched app element
// - source from beacon header; length covers whole element with id and length
// - cover probe, app, app probe, relinquish; probe only if unservable id
// - notify every beacon unless its slot is filtered
// - beacon note carries information length and channel number
// - beacon type zero when not beaconing, or beaconing on a foreign channel
// - own channel: one if aligned, else two overlapping, three otherwise
// - receive time is the 16-bit superframe timing counter at reception
// - link quality 0..255 and signal strength go with the beacon
// - notify on own beacon size change and occupancy element change
// - slot change with no-slot zero after first beacon and on slot moves
// - no slot found, unless a beacon, element or unknown command note wins that cycle: slot change with no-slot one, and stop beaconing in the same cycle
// - notify on channel change element from a neighbor
// - unknown command notifies in any state with its context number
// - command read with interrupt-when-ready sets ready flag
// - event buffer retired sets event-ready flag
// - host bus error clears run, sets host error and halted
// - host errors escalate to a halt of all interface functions
// - function interrupts set source bits in capability order
// - source bits are read-only and follow the function interrupt lines
`timescale 1ns/10ps
`default_nettype none
module rnirq_logic
  import rnirq_pkg::*;
#(
  parameter int NFUNC = ISRC_W
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rstn,
  // Controller state
  input  wire logic             beaconing,
  input  wire logic             scanning,
  input  wire logic [7:0]       own_channel,
  input  wire logic [15:0]      own_dev_addr,
  // Received element
  input  wire logic             ie_valid,
  input  wire logic [7:0]       ie_id,
  input  wire logic [7:0]       ie_len,
  input  wire logic [15:0]      ie_target,
  input  wire logic [15:0]      ie_src,
  input  wire logic             ie_watched,
  input  wire logic             ie_probe_unservable,
  // Received beacon
  input  wire logic             bcn_valid,
  input  wire rnirq_bcn_t       bcn,
  input  wire logic [255:0]     slot_filter,
  // Own beacon events, channel change element and unknown command
  input  wire logic             size_changed,
  input  wire logic             occ_changed,
  input  wire logic             first_beacon_sent,
  input  wire logic             slot_moved,
  input  wire logic [7:0]       new_slot,
  input  wire logic             slot_lost,
  input  wire logic             chan_chg_ie,
  input  wire logic             unk_cmd,
  input  wire logic [7:0]       unk_ctx,
  // Notification output
  output logic                  note_valid,
  output rnirq_note_t           note,
  output logic                  stop_beaconing,
  // Command and status bits
  input  wire logic             cmd_block_read,
  input  wire logic             irq_when_ready,
  input  wire logic             event_retired,
  input  wire logic             host_err,
  input  wire logic             run_set,
  input  wire logic             ctrl_reset,
  input  wire logic             clr_ready,
  input  wire logic             clr_event,
  input  wire logic             clr_hse,
  output logic                  run,
  output logic                  ready_for_command_flag,
  output logic                  event_ready_flag,
  output logic                  host_sys_err,
  output logic                  halted,
  output logic                  halt_all,
  // Interrupt enables and sources
  input  wire logic             en_ready,
  input  wire logic             en_event,
  input  wire logic             en_hse,
  input  wire logic [NFUNC-1:0] en_src,
  input  wire logic [NFUNC-1:0] func_irq,
  output logic [NFUNC-1:0]      interrupt_source_field,
  output logic                  irq
);

  function automatic logic [1:0] beacon_type(input rnirq_bcn_t b);
    if (!beaconing || b.channel != own_channel)
      return BT_SCAN;
    else if (b.beacon_period_start_time_aligned)
      return BT_NEIGHBOR;
    else if (b.bp_overlap)
      return BT_ALIEN_OVLP;
    else
      return BT_ALIEN_NOVLP;
  endfunction

  logic ie_kind_ok;
  logic ie_hit;
  logic bcn_hit;

  always_comb begin
    case (ie_id)
      EID_PROBE:      ie_kind_ok = ie_probe_unservable;
      EID_APP_SPEC:   ie_kind_ok = 1'b1;
      EID_APP_PROBE:  ie_kind_ok = 1'b1;
      EID_RELINQUISH: ie_kind_ok = 1'b1;
      default:        ie_kind_ok = 1'b0;
    endcase
  end

  assign ie_hit = ie_valid && ie_kind_ok && (ie_target == own_dev_addr || ie_watched);
  assign bcn_hit = bcn_valid && !slot_filter[bcn.slot];

  // One notification per cycle; beacon first, then fixed priority
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      note_valid     <= 1'b0;
      note           <= '0;
      stop_beaconing <= 1'b0;
    end else begin
      note_valid     <= 1'b0;
      stop_beaconing <= 1'b0;
      note           <= '0;
      if (bcn_hit) begin
        note_valid       <= 1'b1;
        note.kind        <= RNIRQ_N_BCN_RX;
        note.src_addr    <= bcn.src_addr;
        note.length      <= bcn.info_len;
        note.channel     <= bcn.channel;
        note.beacon_type <= beacon_type(bcn);
        note.rx_time     <= bcn.rx_time;
        note.lqi         <= bcn.lqi;
        note.rssi        <= bcn.rssi;
        note.slot        <= bcn.slot;
      end else if (ie_hit) begin
        note_valid    <= 1'b1;
        note.kind     <= RNIRQ_N_IE_RX;
        note.src_addr <= ie_src;
        note.length   <= 16'(ie_len) + 16'h0002;
      end else if (unk_cmd) begin
        note_valid      <= 1'b1;
        note.kind       <= RNIRQ_N_UNK_CMD;
        note.context_id <= unk_ctx;
      end else if (slot_lost) begin
        note_valid     <= 1'b1;
        note.kind      <= RNIRQ_N_SLOT_CHG;
        note.no_slot   <= 1'b1;
        stop_beaconing <= 1'b1;
      end else if (first_beacon_sent || slot_moved) begin
        note_valid <= 1'b1;
        note.kind  <= RNIRQ_N_SLOT_CHG;
        note.slot  <= new_slot;
      end else if (chan_chg_ie) begin
        note_valid <= 1'b1;
        note.kind  <= RNIRQ_N_CHAN_CHG;
      end else if (size_changed || occ_changed) begin
        note_valid <= 1'b1;
        note.kind  <= size_changed ? RNIRQ_N_BCN_SIZE : RNIRQ_N_OCC_CHG;
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn)
      ready_for_command_flag <= 1'b0;
    else if (cmd_block_read && irq_when_ready)
      ready_for_command_flag <= 1'b1;
    else if (clr_ready || ctrl_reset)
      ready_for_command_flag <= 1'b0;
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn)
      event_ready_flag <= 1'b0;
    else if (event_retired)
      event_ready_flag <= 1'b1;
    else if (clr_event || ctrl_reset)
      event_ready_flag <= 1'b0;
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      run          <= 1'b0;
      host_sys_err <= 1'b0;
      halted       <= 1'b1;
    end else if (host_err) begin
      run          <= 1'b0;
      host_sys_err <= 1'b1;
      halted       <= 1'b1;
    end else if (ctrl_reset) begin
      run          <= 1'b0;
      host_sys_err <= 1'b0;
      halted       <= 1'b1;
    end else begin
      if (clr_hse)
        host_sys_err <= 1'b0;
      if (run_set && !host_sys_err) begin
        run    <= 1'b1;
        halted <= 1'b0;
      end
    end
  end

  assign halt_all = host_sys_err;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn)
      interrupt_source_field <= '0;
    else
      interrupt_source_field <= func_irq;
  end

  assign irq = (ready_for_command_flag && en_ready) || (event_ready_flag && en_event) ||
               (host_sys_err && en_hse) || |(interrupt_source_field & en_src);

  // Checks
  a_ie_length: assert property (@(posedge clk) disable iff (!rstn)
    ie_hit && !bcn_hit |=> note_valid && note.length == $past(16'(ie_len)) + 16'h0002)
    else $error("element length wrong");
  a_bcn_filtered: assert property (@(posedge clk) disable iff (!rstn)
    bcn_valid && !slot_filter[bcn.slot] |=> note_valid && note.kind == RNIRQ_N_BCN_RX)
    else $error("beacon not notified");
  a_scan_type: assert property (@(posedge clk) disable iff (!rstn)
    bcn_hit && !beaconing |=> note.beacon_type == BT_SCAN)
    else $error("scan type wrong");
  a_rx_time: assert property (@(posedge clk) disable iff (!rstn)
    bcn_hit |=> note.rx_time == $past(bcn.rx_time))
    else $error("receive time wrong");
  a_slot_lost: assert property (@(posedge clk) disable iff (!rstn)
    slot_lost && !bcn_hit && !ie_hit && !unk_cmd |=>
      stop_beaconing && note_valid && note.no_slot && note.kind == RNIRQ_N_SLOT_CHG)
    else $error("stop without no-slot note");
  a_ready_set: assert property (@(posedge clk) disable iff (!rstn)
    cmd_block_read && irq_when_ready |=> ready_for_command_flag)
    else $error("ready flag not set");
  a_event_set: assert property (@(posedge clk) disable iff (!rstn)
    event_retired |=> event_ready_flag && (!en_event || irq))
    else $error("event flag or irq missing");
  a_host_err: assert property (@(posedge clk) disable iff (!rstn)
    host_err |=> !run && host_sys_err && halted)
    else $error("host error response wrong");
  a_src_follow: assert property (@(posedge clk) disable iff (!rstn)
    $fell(func_irq[0]) |=> !interrupt_source_field[0])
    else $error("source bit not cleared");
  a_irq_mask: assert property (@(posedge clk) disable iff (!rstn)
    !en_ready && !en_event && !en_hse && en_src == '0 |-> !irq)
    else $error("irq without enable");

endmodule
`default_nettype wire

// File: test/rnirq_host_model.sv
`timescale 1ns/10ps
`default_nettype none
module rnirq_host_model #(
  parameter int DLY = 2
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rstn,
  // Status seen by software
  input  wire logic event_ready_flag,
  input  wire logic host_sys_err,
  // Acknowledge pulses
  output logic      clr_event,
  output logic      ctrl_reset
);
  int wait_n;
  // Software answers DLY+1 cycles after a flag is seen, one fixed delay per instance
  // consume retired event, or reset the controller after a host error
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wait_n     <= 0;
      clr_event  <= 1'b0;
      ctrl_reset <= 1'b0;
    end else begin
      clr_event  <= 1'b0;
      ctrl_reset <= 1'b0;
      if ((event_ready_flag || host_sys_err) && !clr_event && !ctrl_reset) begin
        if (wait_n == DLY) begin
          wait_n     <= 0;
          clr_event  <= event_ready_flag;
          ctrl_reset <= host_sys_err;
        end else begin
          wait_n <= wait_n + 1;
        end
      end
    end
  end
endmodule
`default_nettype wire

// File: test/radio_notify_irq_logic_test.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, a) begin cmp_count++; if ((a) !== (e)) begin n_mismatch++; \
  $display("ERROR %s exp %0h seen %0h", n, e, a); end end
module radio_notify_irq_logic_test;
  import rnirq_pkg::*;
  logic clk = 0, rstn = 0, beaconing = 0, scanning = 0, ie_watched = 0, ie_probe_unservable = 0;
  logic irq_when_ready = 0, en_ready = 0, en_event = 0, en_hse = 0, same, sig;
  logic [7:0] own_channel = 8'h05, ie_id = 8'h00, ie_len = 8'h04, new_slot = 8'h00;
  logic [7:0] unk_ctx = 8'h00, en_src = 8'h00, func_irq = 8'h00;
  logic [15:0] own_dev_addr = 16'h1234, ie_target = 16'h1234, ie_src = 16'hCAFE;
  logic [14:0] ev = 15'h0000;
  logic [255:0] slot_filter = '0;
  logic [1:0] bt;
  rnirq_bcn_t bcn = '0;
  rnirq_note_t note;
  logic note_valid, stop_beaconing, ctrl_reset, clr_event, run, ready_for_command_flag;
  logic event_ready_flag, host_sys_err, halted, halt_all, irq;
  logic [7:0] interrupt_source_field;
  logic [7:0] rows [6] = '{8'h40, 8'hD8, 8'hB2, 8'hAC, 8'hA6, 8'hB1};
  logic [7:0] ids [4] = '{EID_PROBE, EID_APP_SPEC, EID_APP_PROBE, EID_RELINQUISH};
  int n_mismatch = 0, cmp_count = 0, n_cyc = 0;

  rnirq_logic u_dut (.clk, .rstn, .beaconing, .scanning, .own_channel, .own_dev_addr,
    .ie_valid(ev[0]), .ie_id, .ie_len, .ie_target, .ie_src, .ie_watched,
    .ie_probe_unservable, .bcn_valid(ev[1]), .bcn, .slot_filter, .size_changed(ev[2]),
    .occ_changed(ev[3]), .first_beacon_sent(ev[4]), .slot_moved(ev[5]), .new_slot,
    .slot_lost(ev[6]), .chan_chg_ie(ev[7]), .unk_cmd(ev[8]), .unk_ctx, .note_valid, .note,
    .stop_beaconing, .cmd_block_read(ev[9]), .irq_when_ready, .event_retired(ev[10]),
    .host_err(ev[11]), .run_set(ev[12]), .ctrl_reset, .clr_ready(ev[13]), .clr_event,
    .clr_hse(ev[14]), .run, .ready_for_command_flag, .event_ready_flag, .host_sys_err,
    .halted, .halt_all, .en_ready, .en_event, .en_hse, .en_src, .func_irq,
    .interrupt_source_field, .irq);
  rnirq_host_model u_host (.clk, .rstn, .event_ready_flag, .host_sys_err, .clr_event,
    .ctrl_reset);

  initial begin
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk) begin
    n_cyc++;
    if (n_cyc == 4000) begin
      n_mismatch++;
      summarize;
    end
  end
  task summarize;
    $display("checks %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task cyc;
    @(negedge clk);
  endtask
  task pulse(input int b);
    ev[b] = 1'b1;
    cyc;
    ev = 15'h0000;
  endtask
  task nchk(input rnirq_kind_t k);
    `CHK("note_valid", 1'b1, note_valid)
    `CHK("kind", k, note.kind)
  endtask

  initial begin
    repeat (16) @(posedge clk);
    `CHK("irq", 1'b0, irq)
    cyc;
    rstn = 1'b1;
    bcn = '{16'hBEEF, 16'h0040, 8'h05, 16'hFFFF, 8'hFF, 8'h80, 8'h03, 1'b0, 1'b0, 1'b0};
    for (int i = 0; i < 6; i++) begin
      {beaconing, scanning, same, bcn.beacon_period_start_time_aligned, bcn.bp_overlap, bt, sig} = rows[i];
      bcn.signaling_slot = sig;
      bcn.channel = same ? 8'h05 : 8'h09;
      pulse(1);
      nchk(RNIRQ_N_BCN_RX);
      if (!sig) `CHK("beacon_type", bt, note.beacon_type)
      `CHK("length", 16'h0040, note.length)
      `CHK("channel", bcn.channel, note.channel)
      `CHK("rx_time", 16'hFFFF, note.rx_time)
      `CHK("lqi", 8'hFF, note.lqi)
      `CHK("rssi", 8'h80, note.rssi)
    end
    slot_filter[3] = 1'b1;
    pulse(1);
    `CHK("filtered", 1'b0, note_valid)
    ie_probe_unservable = 1'b1;
    for (int i = 0; i < 4; i++) begin
      ie_id = ids[i];
      pulse(0);
      nchk(RNIRQ_N_IE_RX);
      `CHK("ie_length", 16'h0006, note.length)
      `CHK("ie_src", 16'hCAFE, note.src_addr)
    end
    ie_id = EID_PROBE;
    ie_probe_unservable = 1'b0;
    pulse(0);
    `CHK("probe", 1'b0, note_valid)
    ie_id = EID_APP_SPEC;
    ie_target = 16'h0001;
    pulse(0);
    `CHK("unwatched", 1'b0, note_valid)
    ie_watched = 1'b1;
    pulse(0);
    nchk(RNIRQ_N_IE_RX);
    pulse(2);
    nchk(RNIRQ_N_BCN_SIZE);
    pulse(3);
    nchk(RNIRQ_N_OCC_CHG);
    pulse(7);
    nchk(RNIRQ_N_CHAN_CHG);
    new_slot = 8'h07;
    pulse(4);
    nchk(RNIRQ_N_SLOT_CHG);
    `CHK("slot", 8'h07, note.slot)
    `CHK("no_slot", 1'b0, note.no_slot)
    new_slot = 8'h09;
    pulse(5);
    `CHK("slot", 8'h09, note.slot)
    pulse(6);
    nchk(RNIRQ_N_SLOT_CHG);
    `CHK("no_slot", 1'b1, note.no_slot)
    `CHK("stop", 1'b1, stop_beaconing)
    beaconing = 1'b0;
    unk_ctx = 8'hA5;
    pulse(8);
    nchk(RNIRQ_N_UNK_CMD);
    `CHK("context", 8'hA5, note.context_id)
    pulse(9);
    `CHK("ready", 1'b0, ready_for_command_flag)
    irq_when_ready = 1'b1;
    en_ready = 1'b1;
    pulse(9);
    `CHK("ready", 1'b1, ready_for_command_flag)
    `CHK("irq", 1'b1, irq)
    pulse(13);
    `CHK("irq", 1'b0, irq)
    for (int j = 0; j < 2; j++) begin
      en_event = j[0];
      pulse(10);
      `CHK("event", 1'b1, event_ready_flag)
      `CHK("irq", j[0], irq)
      for (int k = 0; k < 8 && event_ready_flag; k++) cyc;
      `CHK("irq", 1'b0, irq)
    end
    en_src = 8'h04;
    func_irq = 8'h07;
    cyc;
    `CHK("source", 8'h07, interrupt_source_field)
    `CHK("irq", 1'b1, irq)
    en_src = 8'h08;
    cyc;
    `CHK("irq", 1'b0, irq)
    func_irq = 8'h00;
    cyc;
    `CHK("source", 8'h00, interrupt_source_field)
    pulse(12);
    `CHK("run", 1'b1, run)
    en_hse = 1'b1;
    pulse(11);
    `CHK("run", 1'b0, run)
    `CHK("hse", 1'b1, host_sys_err)
    `CHK("halted", 1'b1, halted)
    `CHK("halt_all", 1'b1, halt_all)
    `CHK("irq", 1'b1, irq)
    pulse(12);
    `CHK("run", 1'b0, run)
    for (int k = 0; k < 16 && host_sys_err; k++) cyc;
    `CHK("hse", 1'b0, host_sys_err)
    `CHK("halted", 1'b1, halted)
    // Mid-run reset with flags and run set
    pulse(12);
    pulse(9);
    pulse(10);
    `CHK("run", 1'b1, run)
    `CHK("ready", 1'b1, ready_for_command_flag)
    rstn = 1'b0;
    cyc;
    `CHK("rst_run", 1'b0, run)
    `CHK("rst_halted", 1'b1, halted)
    `CHK("rst_ready", 1'b0, ready_for_command_flag)
    `CHK("rst_event", 1'b0, event_ready_flag)
    `CHK("rst_irq", 1'b0, irq)
    rstn = 1'b1;
    cyc;
    `CHK("rel_note", 1'b0, note_valid)
    `CHK("rel_run", 1'b0, run)
    `CHK("rel_irq", 1'b0, irq)
    summarize;
  end
endmodule
`default_nettype wire
